// file: common/standby_pkg.sv
package standby_pkg;
    // =====================================================
    // register byte addresses
    localparam logic [7:0] ADDR_SYS_CTRL_TWO = 8'h00;
    localparam logic [7:0] ADDR_IRQ_MASTER   = 8'h04;
    localparam logic [7:0] ADDR_IRQ_SRC_EN   = 8'h08;
    localparam logic [7:0] ADDR_IRQ_PENDING  = 8'h0C;
    localparam logic [7:0] ADDR_BASE_TICK    = 8'h10;
    localparam logic [7:0] ADDR_MODE_STATUS  = 8'h14;
    // =====================================================
    // sys_ctrl_two fields
    localparam int FAST_OSC_ON_BIT  = 7;
    localparam int SLOW_OSC_ON_BIT  = 6;
    localparam int MAIN_CLK_SEL_BIT = 5;
    localparam int CPU_PAUSE_BIT    = 4;
    localparam int TG_STOP_BIT      = 2;
    // base_tick_ctrl fields
    localparam int TICK_ON_BIT      = 3;
    localparam int TICK_SEL_LSB     = 0;
    // =====================================================
    // interrupt sources
    localparam int NUM_IRQ          = 8;
    localparam int ID_W             = 3;
    localparam logic [2:0] WDOG_IDX = 3'h0;
    localparam logic [2:0] TICK_IDX = 3'h6;
    localparam int NUM_TICK_SRC     = 4;
    localparam int TICK_SEL_W       = 2;
    // =====================================================
    // reset values and answers
    localparam logic       FAST_OSC_RST = 1'b1;
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;
    // =====================================================
    // operating mode codes shown in the status register
    localparam logic [2:0] OP_RUN_HIGH_SINGLE   = 3'h0;
    localparam logic [2:0] OP_RUN_HIGH_DUAL     = 3'h1;
    localparam logic [2:0] OP_RUN_LOW_XON       = 3'h2;
    localparam logic [2:0] OP_RUN_LOW_XOFF      = 3'h3;
    localparam logic [2:0] OP_CPU_PAUSE_HIGHCLK = 3'h4;
    localparam logic [2:0] OP_CPU_PAUSE_LOWCLK  = 3'h5;
    localparam logic [2:0] OP_TG_PAUSE_HIGHCLK  = 3'h6;
    localparam logic [2:0] OP_TG_PAUSE_LOWCLK   = 3'h7;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_CPU_PAUSE,
        ST_TG_PAUSE
    } mode_type;
endpackage

// file: src/standby_mode_controller.sv
// Notes on behaviour
// - cpu pause halts cpu and wdog; peripherals keep their clock.
// - every pause keeps memory, registers, status word and port latches.
// - program counter stays two bytes past the entry instruction.
// - leaving cpu pause clears cpu_pause_req and restores prior mode.
// - reset ends any pause; afterwards run_high_single.
// - master enable 0: enabled interrupt wakes without being taken.
// - master enable 1: enabled interrupt wakes and is serviced.
// - wdog interrupt just before cpu pause is serviced; no pause.
// - timing-generator pause stops clocks except base_tick_timer.
// - leaving tg pause clears tg_stop_req and restores prior mode.
// - base_tick_on set at entry sets base_tick_irq latch.
// - product 0: selected tick falling edge wakes, no service.
// - product 1: selected tick falling edge wakes and services tick.
// - tg pause may end sooner than one full tick period.
// - wdog interrupt just before tg pause is serviced; no pause.
// - reset request when the selected clock's oscillator is disabled.
module standby_mode_controller (
    input  wire logic                               clk,
    input  wire logic                               nrst,
    input  wire logic [7:0]                         s_axi_awaddr,
    input  wire logic                               s_axi_awvalid,
    output logic                                    s_axi_awready,
    input  wire logic [31:0]                        s_axi_wdata,
    input  wire logic [3:0]                         s_axi_wstrb,
    input  wire logic                               s_axi_wvalid,
    output logic                                    s_axi_wready,
    output logic [1:0]                              s_axi_bresp,
    output logic                                    s_axi_bvalid,
    input  wire logic                               s_axi_bready,
    input  wire logic [7:0]                         s_axi_araddr,
    input  wire logic                               s_axi_arvalid,
    output logic                                    s_axi_arready,
    output logic [31:0]                             s_axi_rdata,
    output logic [1:0]                              s_axi_rresp,
    output logic                                    s_axi_rvalid,
    input  wire logic                               s_axi_rready,
    input  wire logic [standby_pkg::NUM_IRQ-1:0]    irq_req,
    input  wire logic [standby_pkg::NUM_TICK_SRC-1:0] tick_src,
    output logic                                    cpu_halt,
    output logic                                    wdog_halt,
    output logic                                    periph_clk_en,
    output logic                                    irq_take,
    output logic [standby_pkg::ID_W-1:0]            irq_take_id,
    output logic                                    fast_osc_en,
    output logic                                    slow_osc_en,
    output logic                                    main_clk_low,
    output logic                                    sys_reset_req
);
    // =====================================================
    // state
    typedef struct packed {
        logic                          aw_rdy;
        logic                          b_vld;
        logic [1:0]                    b_resp;
        logic                          ar_rdy;
        logic                          r_vld;
        logic [1:0]                    r_resp;
        logic [31:0]                   r_data;
        standby_pkg::mode_type         mode;
        logic                          fast_on;
        logic                          slow_on;
        logic                          clk_sel;
        logic                          pause_req;
        logic                          tg_req;
        logic                          master_en;
        logic [standby_pkg::NUM_IRQ-1:0] src_en;
        logic [standby_pkg::NUM_IRQ-1:0] pend;
        logic                          tick_on;
        logic [standby_pkg::TICK_SEL_W-1:0] tick_sel;
        logic                          tick_prev;
        logic                          take;
        logic [standby_pkg::ID_W-1:0]  take_id;
        logic                          halt;
        logic                          periph_en;
        logic                          rst_req;
    } state_type;

    state_type s;
    state_type next_s;

    function automatic logic [standby_pkg::ID_W-1:0] lowest(
        input logic [standby_pkg::NUM_IRQ-1:0] v);
        logic [standby_pkg::ID_W-1:0] r;
        r = '0;
        for (int i = standby_pkg::NUM_IRQ - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = standby_pkg::ID_W'(i);
            end
        end
        return r;
    endfunction

    function automatic logic [2:0] op_code(input state_type x);
        logic [2:0] c;
        c = x.clk_sel ? (x.fast_on ? standby_pkg::OP_RUN_LOW_XON
                                   : standby_pkg::OP_RUN_LOW_XOFF)
                      : (x.slow_on ? standby_pkg::OP_RUN_HIGH_DUAL
                                   : standby_pkg::OP_RUN_HIGH_SINGLE);
        if (x.mode == standby_pkg::ST_CPU_PAUSE) begin
            c = x.clk_sel ? standby_pkg::OP_CPU_PAUSE_LOWCLK
                          : standby_pkg::OP_CPU_PAUSE_HIGHCLK;
        end else if (x.mode == standby_pkg::ST_TG_PAUSE) begin
            c = x.clk_sel ? standby_pkg::OP_TG_PAUSE_LOWCLK
                          : standby_pkg::OP_TG_PAUSE_HIGHCLK;
        end
        return c;
    endfunction

    logic                          wr_go;
    logic                          rd_go;
    logic                          tick_now;
    logic                          tick_fall;
    logic                          wdog_hit;
    logic [standby_pkg::NUM_IRQ-1:0] wake_vec;

    assign wr_go    = s.aw_rdy && s_axi_awvalid && s_axi_wvalid;
    assign rd_go    = s.ar_rdy && s_axi_arvalid;
    assign tick_now = tick_src[s.tick_sel];
    assign tick_fall = s.tick_prev && !tick_now;
    assign wdog_hit = s.pend[standby_pkg::WDOG_IDX] || irq_req[standby_pkg::WDOG_IDX];
    assign wake_vec = (s.pend | irq_req) & s.src_en;

    // =====================================================
    // next state
    always_comb begin
        next_s           = s;
        next_s.take      = 1'b0;
        next_s.tick_prev = tick_now;
        // hardware set wins over a software clear in the same cycle
        next_s.pend      = s.pend | irq_req;

        // bus: ready is raised one cycle after both channels are offered
        next_s.aw_rdy = s_axi_awvalid && s_axi_wvalid && !s.aw_rdy && !s.b_vld;
        next_s.ar_rdy = s_axi_arvalid && !s.ar_rdy && !s.r_vld;
        if (s.b_vld && s_axi_bready) begin
            next_s.b_vld = 1'b0;
        end
        if (s.r_vld && s_axi_rready) begin
            next_s.r_vld = 1'b0;
        end

        if (wr_go) begin
            next_s.b_vld  = 1'b1;
            next_s.b_resp = standby_pkg::RESP_OKAY;
            case (s_axi_awaddr)
                standby_pkg::ADDR_SYS_CTRL_TWO: begin
                    if (s_axi_wstrb[0]) begin
                        next_s.fast_on = s_axi_wdata[standby_pkg::FAST_OSC_ON_BIT];
                        next_s.slow_on = s_axi_wdata[standby_pkg::SLOW_OSC_ON_BIT];
                        next_s.clk_sel = s_axi_wdata[standby_pkg::MAIN_CLK_SEL_BIT];
                        if (s.mode == standby_pkg::ST_RUN) begin
                            // cpu pause wins if both are requested together
                            if (s_axi_wdata[standby_pkg::CPU_PAUSE_BIT] ||
                                s_axi_wdata[standby_pkg::TG_STOP_BIT]) begin
                                if (wdog_hit) begin
                                    next_s.take    = 1'b1;
                                    next_s.take_id = standby_pkg::WDOG_IDX;
                                    next_s.pend[standby_pkg::WDOG_IDX] = 1'b0;
                                end else if (s_axi_wdata[standby_pkg::CPU_PAUSE_BIT]) begin
                                    next_s.mode      = standby_pkg::ST_CPU_PAUSE;
                                    next_s.pause_req = 1'b1;
                                end else begin
                                    next_s.mode   = standby_pkg::ST_TG_PAUSE;
                                    next_s.tg_req = 1'b1;
                                    if (s.tick_on) begin
                                        next_s.pend[standby_pkg::TICK_IDX] = 1'b1;
                                    end
                                end
                            end
                        end
                    end
                end
                standby_pkg::ADDR_IRQ_MASTER: begin
                    if (s_axi_wstrb[0]) begin
                        next_s.master_en = s_axi_wdata[0];
                    end
                end
                standby_pkg::ADDR_IRQ_SRC_EN: begin
                    if (s_axi_wstrb[0]) begin
                        next_s.src_en = s_axi_wdata[standby_pkg::NUM_IRQ-1:0];
                    end
                end
                standby_pkg::ADDR_IRQ_PENDING: begin
                    if (s_axi_wstrb[0]) begin
                        next_s.pend = s_axi_wdata[standby_pkg::NUM_IRQ-1:0] | irq_req;
                    end
                end
                standby_pkg::ADDR_BASE_TICK: begin
                    if (s_axi_wstrb[0]) begin
                        next_s.tick_on  = s_axi_wdata[standby_pkg::TICK_ON_BIT];
                        next_s.tick_sel = s_axi_wdata[standby_pkg::TICK_SEL_LSB +:
                                                      standby_pkg::TICK_SEL_W];
                    end
                end
                standby_pkg::ADDR_MODE_STATUS: begin
                end
                default: begin
                    next_s.b_resp = standby_pkg::RESP_SLVERR;
                end
            endcase
        end

        // =================================================
        // pause release
        case (s.mode)
            standby_pkg::ST_RUN: begin
            end
            standby_pkg::ST_CPU_PAUSE: begin
                if (|wake_vec) begin
                    next_s.mode      = standby_pkg::ST_RUN;
                    next_s.pause_req = 1'b0;
                    if (s.master_en) begin
                        next_s.take    = 1'b1;
                        next_s.take_id = lowest(wake_vec);
                        next_s.pend[lowest(wake_vec)] = irq_req[lowest(wake_vec)];
                    end
                    // else resume at the next instruction, latch left set
                end
            end
            standby_pkg::ST_TG_PAUSE: begin
                // release is on the edge itself, not a full tick period
                if (tick_fall) begin
                    next_s.mode   = standby_pkg::ST_RUN;
                    next_s.tg_req = 1'b0;
                    if (s.master_en && s.src_en[standby_pkg::TICK_IDX] && s.tick_on) begin
                        next_s.take    = 1'b1;
                        next_s.take_id = standby_pkg::TICK_IDX;
                        next_s.pend[standby_pkg::TICK_IDX] =
                            irq_req[standby_pkg::TICK_IDX];
                    end
                    // product 0: wake only
                end
            end
            default: begin
                next_s.mode = standby_pkg::ST_RUN;
            end
        endcase

        // any pause holds cpu state and pc: the cpu simply gets no clock
        next_s.halt      = next_s.mode != standby_pkg::ST_RUN;
        next_s.periph_en = next_s.mode != standby_pkg::ST_TG_PAUSE;
        next_s.rst_req   = (!next_s.fast_on && !next_s.slow_on) ||
                           (!next_s.clk_sel && !next_s.fast_on) ||
                           (next_s.clk_sel && !next_s.slow_on);

        if (rd_go) begin
            next_s.r_vld  = 1'b1;
            next_s.r_resp = standby_pkg::RESP_OKAY;
            next_s.r_data = '0;
            case (s_axi_araddr)
                standby_pkg::ADDR_SYS_CTRL_TWO: begin
                    next_s.r_data[standby_pkg::FAST_OSC_ON_BIT]  = s.fast_on;
                    next_s.r_data[standby_pkg::SLOW_OSC_ON_BIT]  = s.slow_on;
                    next_s.r_data[standby_pkg::MAIN_CLK_SEL_BIT] = s.clk_sel;
                    next_s.r_data[standby_pkg::CPU_PAUSE_BIT]    = s.pause_req;
                    next_s.r_data[standby_pkg::TG_STOP_BIT]      = s.tg_req;
                end
                standby_pkg::ADDR_IRQ_MASTER: begin
                    next_s.r_data[0] = s.master_en;
                end
                standby_pkg::ADDR_IRQ_SRC_EN: begin
                    next_s.r_data[standby_pkg::NUM_IRQ-1:0] = s.src_en;
                end
                standby_pkg::ADDR_IRQ_PENDING: begin
                    next_s.r_data[standby_pkg::NUM_IRQ-1:0] = s.pend;
                end
                standby_pkg::ADDR_BASE_TICK: begin
                    next_s.r_data[standby_pkg::TICK_ON_BIT] = s.tick_on;
                    next_s.r_data[standby_pkg::TICK_SEL_LSB +:
                                  standby_pkg::TICK_SEL_W] = s.tick_sel;
                end
                standby_pkg::ADDR_MODE_STATUS: begin
                    next_s.r_data[2:0] = op_code(s);
                end
                default: begin
                    next_s.r_resp = standby_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    // reset lands in run_high_single and ends any pause
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s         <= '0;
            s.fast_on <= standby_pkg::FAST_OSC_RST;
            s.halt    <= 1'b0;
            s.periph_en <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // =====================================================
    // outputs
    assign s_axi_awready = s.aw_rdy;
    assign s_axi_wready  = s.aw_rdy;
    assign s_axi_bvalid  = s.b_vld;
    assign s_axi_bresp   = s.b_resp;
    assign s_axi_arready = s.ar_rdy;
    assign s_axi_rvalid  = s.r_vld;
    assign s_axi_rresp   = s.r_resp;
    assign s_axi_rdata   = s.r_data;
    assign cpu_halt      = s.halt;
    assign wdog_halt     = s.halt;
    assign periph_clk_en = s.periph_en;
    assign irq_take      = s.take;
    assign irq_take_id   = s.take_id;
    assign fast_osc_en   = s.fast_on;
    assign slow_osc_en   = s.slow_on;
    assign main_clk_low  = s.clk_sel;
    assign sys_reset_req = s.rst_req;

    // =====================================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_halt_in_pause;
        s.mode == standby_pkg::ST_CPU_PAUSE |-> cpu_halt && wdog_halt && periph_clk_en;
    endproperty
    a_halt_in_pause: assert property (p_halt_in_pause) else $error("pause not halting");

    property p_tg_gate;
        s.mode == standby_pkg::ST_TG_PAUSE |-> !periph_clk_en && cpu_halt;
    endproperty
    a_tg_gate: assert property (p_tg_gate) else $error("peripheral clock on in tg pause");

    property p_cpu_release;
        s.mode == standby_pkg::ST_CPU_PAUSE && |wake_vec
            |=> s.mode == standby_pkg::ST_RUN && !s.pause_req;
    endproperty
    a_cpu_release: assert property (p_cpu_release) else $error("cpu pause not released");

    property p_wake_no_take;
        s.mode == standby_pkg::ST_CPU_PAUSE && |wake_vec && !s.master_en |=> !irq_take;
    endproperty
    a_wake_no_take: assert property (p_wake_no_take) else $error("irq taken with master off");

    property p_wake_take;
        s.mode == standby_pkg::ST_CPU_PAUSE && |wake_vec && s.master_en
            |=> irq_take && irq_take_id == $past(lowest(wake_vec));
    endproperty
    a_wake_take: assert property (p_wake_take) else $error("wake irq not taken");

    property p_tg_release;
        s.mode == standby_pkg::ST_TG_PAUSE && tick_fall
            |=> s.mode == standby_pkg::ST_RUN && !s.tg_req &&
                (irq_take == $past(s.master_en && s.src_en[standby_pkg::TICK_IDX] && s.tick_on));
    endproperty
    a_tg_release: assert property (p_tg_release) else $error("tg release wrong");

    property p_wdog_block;
        s.mode == standby_pkg::ST_RUN && wr_go && wdog_hit && s_axi_wstrb[0] &&
        s_axi_awaddr == standby_pkg::ADDR_SYS_CTRL_TWO &&
        (s_axi_wdata[standby_pkg::CPU_PAUSE_BIT] || s_axi_wdata[standby_pkg::TG_STOP_BIT])
            |=> s.mode == standby_pkg::ST_RUN && irq_take &&
                irq_take_id == standby_pkg::WDOG_IDX;
    endproperty
    a_wdog_block: assert property (p_wdog_block) else $error("pause entered over wdog");

    property p_tick_latch;
        $rose(s.tg_req) && $past(s.tick_on) |-> s.pend[standby_pkg::TICK_IDX];
    endproperty
    a_tick_latch: assert property (p_tick_latch) else $error("tick latch not set");

    property p_osc_reset;
        s.clk_sel && !s.slow_on |-> sys_reset_req;
    endproperty
    a_osc_reset: assert property (p_osc_reset) else $error("no reset on dead clock");

    property p_bresp;
        wr_go |=> s_axi_bvalid;
    endproperty
    a_bresp: assert property (p_bresp) else $error("write not answered");

    c_cpu_pause: cover property (s.mode == standby_pkg::ST_CPU_PAUSE ##1 irq_take);
    c_tg_pause: cover property (s.mode == standby_pkg::ST_TG_PAUSE ##1
                                s.mode == standby_pkg::ST_RUN);
    c_wdog: cover property (irq_take && irq_take_id == standby_pkg::WDOG_IDX);
endmodule

// file: tb/standby_mode_controller_tb.sv
module standby_mode_controller_tb;
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================
    // stimulus and observed signals
    logic        clk = 0, nrst = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, irq = 8'h00;
    logic [31:0] wdata = 32'h0, rd_d;
    logic [3:0]  tick = 4'h0;
    logic        awr, wr_rdy, bvalid, arr, rvalid, halt, whalt, pclk, take, fosc, sosc, mlow, rreq;
    logic [1:0]  bresp, rresp, rd_r;
    logic [31:0] rdata;
    logic [2:0]  take_id, last_id;
    int          err_total = 0, check_count = 0, takes = 0, t0;
    initial forever #10 clk = ~clk;
    always @(posedge clk) if (take === 1'b1) begin takes <= takes + 1; last_id <= take_id; end
    standby_mode_controller u_standby_mode_controller (.clk(clk), .nrst(nrst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq_req(irq), .tick_src(tick),
        .cpu_halt(halt), .wdog_halt(whalt), .periph_clk_en(pclk), .irq_take(take),
        .irq_take_id(take_id), .fast_osc_en(fosc), .slow_osc_en(sosc), .main_clk_low(mlow),
        .sys_reset_req(rreq));
    // ==========================================
    // shared tasks
    task summarize;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
        check_count++;
        if (seen !== exp) begin err_total++; $display("mismatch at %0t: %s", $time, m); end
    endtask
    task tmo(input int n);
        if (n >= 60) begin err_total++; $display("mismatch at %0t: timeout", $time); summarize(); end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk); awaddr <= a; wdata <= d; awv <= 1; wv <= 1;
        // each channel is released at the edge where its own ready is seen
        do begin @(posedge clk); n++; if (awr === 1'b1) awv <= 0; if (wr_rdy === 1'b1) wv <= 0;
        end while (!(awr === 1'b1 || wr_rdy === 1'b1) && n < 60);
        tmo(n); bready <= 1; n = 0;
        do begin @(posedge clk); n++; end while (bvalid !== 1'b1 && n < 60);
        tmo(n); bready <= 0;
        chk(bresp, er, "write response");
    endtask
    task rd(input logic [7:0] a, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk); araddr <= a; arv <= 1;
        do begin @(posedge clk); n++; end while (arr !== 1'b1 && n < 60);
        tmo(n); arv <= 0; rready <= 1; n = 0;
        do begin @(posedge clk); n++; end while (rvalid !== 1'b1 && n < 60);
        tmo(n); rd_d = rdata; rd_r = rresp; rready <= 0;
        chk(rd_r, er, "read response");
    endtask
    task wait_run;
        int n;
        n = 0;
        do begin @(posedge clk); n++; end while (halt !== 1'b0 && n < 60);
        tmo(n); @(posedge clk);
    endtask
    // ==========================================
    // scenarios
    task t_reset;
        chk({halt, whalt, pclk, fosc, sosc, mlow, rreq}, 32'h18, "reset outputs");
        rd(standby_pkg::ADDR_MODE_STATUS, standby_pkg::RESP_OKAY);
        chk(rd_d[2:0], standby_pkg::OP_RUN_HIGH_SINGLE, "mode after reset");
        $display("test reset done");
    endtask
    task t_cpu(input logic m);
        wr(standby_pkg::ADDR_IRQ_MASTER, {31'h0, m}, standby_pkg::RESP_OKAY);
        wr(standby_pkg::ADDR_IRQ_SRC_EN, 32'h08, standby_pkg::RESP_OKAY);
        wr(standby_pkg::ADDR_SYS_CTRL_TWO, 32'h90, standby_pkg::RESP_OKAY);
        chk({halt, whalt, pclk}, 32'h7, "cpu pause outputs");
        rd(standby_pkg::ADDR_MODE_STATUS, standby_pkg::RESP_OKAY);
        chk(rd_d[2:0], standby_pkg::OP_CPU_PAUSE_HIGHCLK, "pause mode");
        t0 = takes;
        @(posedge clk); irq <= 8'h08;
        @(posedge clk); irq <= 8'h00;
        wait_run();
        chk(takes - t0, {31'h0, m}, "service on wake");
        if (m) chk(last_id, 3'h3, "taken id");
        rd(standby_pkg::ADDR_SYS_CTRL_TWO, standby_pkg::RESP_OKAY);
        chk(rd_d[standby_pkg::CPU_PAUSE_BIT], 1'b0, "pause bit cleared");
        rd(standby_pkg::ADDR_MODE_STATUS, standby_pkg::RESP_OKAY);
        chk(rd_d[2:0], standby_pkg::OP_RUN_HIGH_SINGLE, "mode restored");
        rd(standby_pkg::ADDR_IRQ_PENDING, standby_pkg::RESP_OKAY);
        // the request pulse coincides with the take, and a hardware set wins
        chk(rd_d[7:0], 8'h08, "pending after wake");
        wr(standby_pkg::ADDR_IRQ_PENDING, 32'h0, standby_pkg::RESP_OKAY);
        $display("test cpu pause done");
    endtask
    task t_wdog;
        t0 = takes;
        wr(standby_pkg::ADDR_IRQ_PENDING, 32'h01, standby_pkg::RESP_OKAY);
        wr(standby_pkg::ADDR_SYS_CTRL_TWO, 32'h90, standby_pkg::RESP_OKAY);
        repeat (2) @(posedge clk);
        chk(halt, 1'b0, "no pause with wdog pending");
        chk({takes > t0, last_id}, {1'b1, standby_pkg::WDOG_IDX}, "wdog serviced");
        $display("test wdog done");
    endtask
    task t_tg(input logic m);
        wr(standby_pkg::ADDR_IRQ_MASTER, {31'h0, m}, standby_pkg::RESP_OKAY);
        wr(standby_pkg::ADDR_IRQ_SRC_EN, 32'h40, standby_pkg::RESP_OKAY);
        wr(standby_pkg::ADDR_IRQ_PENDING, 32'h0, standby_pkg::RESP_OKAY);
        wr(standby_pkg::ADDR_BASE_TICK, 32'h0A, standby_pkg::RESP_OKAY);
        t0 = takes;
        wr(standby_pkg::ADDR_SYS_CTRL_TWO, 32'h84, standby_pkg::RESP_OKAY);
        chk({halt, pclk}, 32'h2, "tg pause outputs");
        rd(standby_pkg::ADDR_IRQ_PENDING, standby_pkg::RESP_OKAY);
        chk(rd_d[6], 1'b1, "tick latch set at entry");
        // a falling edge on an unselected source must not wake
        @(posedge clk); tick <= 4'h2;
        @(posedge clk); tick <= 4'h0;
        repeat (3) @(posedge clk);
        chk(halt, 1'b1, "still paused");
        @(posedge clk); tick <= 4'h4;
        @(posedge clk); tick <= 4'h0;
        wait_run();
        chk({pclk, 31'(takes - t0)}, {1'b1, 30'h0, m}, "tick wake");
        if (m) chk(last_id, standby_pkg::TICK_IDX, "tick serviced");
        rd(standby_pkg::ADDR_SYS_CTRL_TWO, standby_pkg::RESP_OKAY);
        chk(rd_d[standby_pkg::TG_STOP_BIT], 1'b0, "tg bit cleared");
        $display("test tg pause done");
    endtask
    task t_osc;
        wr(standby_pkg::ADDR_SYS_CTRL_TWO, 32'hC0, standby_pkg::RESP_OKAY);
        rd(standby_pkg::ADDR_MODE_STATUS, standby_pkg::RESP_OKAY);
        chk(rd_d[2:0], standby_pkg::OP_RUN_HIGH_DUAL, "high dual");
        wr(standby_pkg::ADDR_SYS_CTRL_TWO, 32'hE0, standby_pkg::RESP_OKAY);
        rd(standby_pkg::ADDR_MODE_STATUS, standby_pkg::RESP_OKAY);
        chk({rd_d[2:0], mlow, rreq}, {standby_pkg::OP_RUN_LOW_XON, 2'b10}, "low xon");
        wr(standby_pkg::ADDR_SYS_CTRL_TWO, 32'h60, standby_pkg::RESP_OKAY);
        rd(standby_pkg::ADDR_MODE_STATUS, standby_pkg::RESP_OKAY);
        chk({rd_d[2:0], fosc, rreq}, {standby_pkg::OP_RUN_LOW_XOFF, 2'b00}, "low xoff");
        wr(standby_pkg::ADDR_SYS_CTRL_TWO, 32'h70, standby_pkg::RESP_OKAY);
        rd(standby_pkg::ADDR_MODE_STATUS, standby_pkg::RESP_OKAY);
        chk(rd_d[2:0], standby_pkg::OP_CPU_PAUSE_LOWCLK, "low clock pause");
        @(posedge clk); irq <= 8'h40;
        @(posedge clk); irq <= 8'h00;
        wait_run();
        rd(standby_pkg::ADDR_MODE_STATUS, standby_pkg::RESP_OKAY);
        chk(rd_d[2:0], standby_pkg::OP_RUN_LOW_XOFF, "low mode restored");
        wr(standby_pkg::ADDR_SYS_CTRL_TWO, 32'h20, standby_pkg::RESP_OKAY);
        @(posedge clk);
        chk(rreq, 1'b1, "selected oscillator off");
        wr(8'h40, 32'h0, standby_pkg::RESP_SLVERR);
        rd(8'h40, standby_pkg::RESP_SLVERR);
        $display("test oscillator done");
    endtask
    initial begin
        repeat (3) @(posedge clk);
        nrst <= 1;
        t_reset(); t_cpu(1'b0); t_cpu(1'b1); t_wdog(); t_tg(1'b0); t_tg(1'b1); t_osc();
        @(posedge clk); nrst <= 0;
        repeat (2) @(posedge clk); nrst <= 1;
        t_reset();
        summarize();
    end
endmodule
